/* shared/dfe_defines.vh */
// Constants for the disk field CRC and Reed-Solomon check unit
// Behaviour
// - CRC-16 x^16+x^12+x^5+1 on ID fields
// - CRC start value selectable zeros or ones
// - Data fields use interleaved byte-symbol RS code
// - GF(256) from x^8+x^5+x^3+x^2+1, basis beta
// - Alpha is beta to the 88th power
// - Degree 5 roots alpha^253,254,0,1,2
// - Degree 6 roots alpha^125 through alpha^130
// - Degree 6 coefficients 1,176,126,163,126,176,1
// - RS check bytes inverted before writing
// - Read recomputes check bytes, forms composite syndromes
// - Interleave three or five with either degree
// - Syndromes and ECC error status presented
// - Write output muxes data and check bytes
// - Read bytes feed checker and data path
// - Read data sampled on link clock rise
`ifndef DFE_DEFINES_VH
`define DFE_DEFINES_VH

`define DFE_CRC_POLY 16'h1021
`define DFE_CRC_INIT_ZERO 16'h0000
`define DFE_CRC_INIT_ONE 16'hffff
`define DFE_CRC_BYTES 11'h002

`define DFE_GF_POLY_LOW 8'h2d
`define DFE_GF_ONE 8'h01
`define DFE_GF_BETA 8'h02
`define DFE_ALPHA_EXP 8'h58
`define DFE_ROOT_A 8'hfd
`define DFE_ROOT_B 8'hfe
`define DFE_ROOT_C 8'h00
`define DFE_ROOT_D 8'h01
`define DFE_ROOT_E 8'h02
`define DFE_ORDER_LAST 8'hfe

`define DFE_D6_COEFS 48'hb07ea37eb001

`define DFE_CHK_D5_I3 11'h00f
`define DFE_CHK_D5_I5 11'h019
`define DFE_CHK_D6_I3 11'h012
`define DFE_CHK_D6_I5 11'h01e
`define DFE_IL3_LAST 3'h2
`define DFE_IL5_LAST 3'h4
`define DFE_SLOTS 5'h06
`define DFE_CHK_MAX 5'h1e

`define DFE_FIFO_WIDTH 8
`define DFE_FIFO_DEPTH 16
`define DFE_FIFO_AW 4

`endif

/* hw/dfe_fifo.v */
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module dfe_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Fill side
   input wire in_valid,
   input wire [WIDTH-1:0] in_data,
   output reg in_ready,
   // Drain side
   output reg out_valid,
   output wire [WIDTH-1:0] out_data,
   input wire out_ready
);
   localparam [AW:0] FULL_CNT = DEPTH;
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   reg [AW:0] count_next;
   wire push;
   wire pop;

   assign push = in_valid & in_ready;
   assign pop = out_ready & out_valid;
   assign out_data = mem_reg[rd_ptr_reg];

   always @* begin
      count_next = count_reg;
      if (push & ~pop) begin
         count_next = count_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
         count_next = count_reg - {{AW{1'b0}}, 1'b1};
      end
   end

   always @(posedge clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
         count_reg <= count_next;
         in_ready <= (count_next != FULL_CNT);
         out_valid <= (count_next != {(AW+1){1'b0}});
      end
   end
endmodule
`default_nettype wire

/* hw/dfe_error_code_unit.v */
// CRC and interleaved Reed-Solomon check unit for ID and data fields
`timescale 1ns/10ps
`default_nettype none
`include "dfe_defines.vh"
module dfe_error_code_unit (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Disk link
   input wire read_reference_clock,
   input wire serial_read_in,
   output reg serial_write_out,
   // Field control
   input wire field_start,
   input wire field_is_data,
   input wire field_write,
   input wire crc_init_ones,
   input wire ecc_degree6,
   input wire interleave5,
   input wire [10:0] field_len,
   output reg field_busy,
   output reg field_done,
   output reg gen_ready,
   // Write data from buffer
   input wire wr_valid,
   input wire [7:0] wr_data,
   output wire wr_ready,
   output reg wr_underrun,
   // Read data to buffer
   output reg rd_valid,
   output reg [7:0] rd_data,
   // Check status
   output reg crc_error,
   output reg ecc_error,
   input wire [4:0] syndrome_index,
   output reg [7:0] syndrome_byte
);
   localparam [1:0] PH_IDLE = 2'h0;
   localparam [1:0] PH_DATA = 2'h1;
   localparam [1:0] PH_CHECK = 2'h2;
   localparam [1:0] G_BETA = 2'h0;
   localparam [1:0] G_ROOTS = 2'h1;
   localparam [1:0] G_DONE = 2'h2;
   localparam [47:0] D6_COEFS = `DFE_D6_COEFS;

   // GF(256) product, reduced by the field polynomial
   function [7:0] gf_mul;
      input [7:0] a;
      input [7:0] b;
      reg [7:0] acc;
      reg [7:0] sh;
      integer i;
      begin
         acc = 8'h00;
         sh = a;
         for (i = 0; i < 8; i = i + 1) begin
            if (b[i]) begin
               acc = acc ^ sh;
            end
            sh = {sh[6:0], 1'b0} ^ (sh[7] ? `DFE_GF_POLY_LOW : 8'h00);
         end
         gf_mul = acc;
      end
   endfunction

   // CRC update over one byte, most significant bit first
   function [15:0] crc_byte;
      input [15:0] c;
      input [7:0] d;
      reg [15:0] r;
      integer i;
      begin
         r = c;
         for (i = 7; i >= 0; i = i - 1) begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? `DFE_CRC_POLY : 16'h0000);
         end
         crc_byte = r;
      end
   endfunction

   // Link synchronisers
   reg rclk_s1_reg;
   reg rclk_s2_reg;
   reg rclk_s3_reg;
   reg rdat_s1_reg;
   reg rdat_s2_reg;
   // Field state
   reg [1:0] phase_reg;
   reg is_data_reg;
   reg write_reg;
   reg deg6_reg;
   reg il5_reg;
   reg [10:0] len_reg;
   reg [2:0] bit_cnt_reg;
   reg [10:0] byte_cnt_reg;
   reg [2:0] il_reg;
   reg [7:0] sh_reg;
   reg [15:0] crc_reg;
   reg syn_any_reg;
   reg [7:0] rs_mem [0:29];
   reg [7:0] syn_mem [0:29];
   // Generator build engine
   reg [1:0] gst_reg;
   reg [7:0] gcnt_reg;
   reg [7:0] gpow_reg;
   reg [7:0] galpha_reg;
   reg [7:0] c5_mem [0:5];

   wire bit_tick;
   wire [10:0] chk_len;
   wire [2:0] il_last;
   wire [4:0] base;
   wire [7:0] rs_top;
   wire fifo_valid;
   wire [7:0] fifo_data;
   wire load_now;
   wire fifo_pop;
   wire [7:0] tx_byte;
   wire rx_done;
   wire [7:0] rx_byte;
   wire byte_event;
   wire wr_finish;
   wire rs_step;
   wire [7:0] rs_fb;
   wire crc_step;
   wire [15:0] crc_nx;
   wire [7:0] syn_now;
   wire [7:0] gpow_nx;
   wire root_hit;
   wire [7:0] rs_prod [0:5];
   wire [7:0] c5_prod [0:5];

   assign bit_tick = rclk_s2_reg & ~rclk_s3_reg;
   assign chk_len = ~is_data_reg ? `DFE_CRC_BYTES :
                    deg6_reg ? (il5_reg ? `DFE_CHK_D6_I5 : `DFE_CHK_D6_I3) :
                    (il5_reg ? `DFE_CHK_D5_I5 : `DFE_CHK_D5_I3);
   assign il_last = il5_reg ? `DFE_IL5_LAST : `DFE_IL3_LAST;
   assign base = {il_reg, 2'b00} + {1'b0, il_reg, 1'b0};
   assign rs_top = deg6_reg ? rs_mem[base + 5'h05] : rs_mem[base + 5'h04];

   assign load_now = bit_tick & write_reg & (bit_cnt_reg == 3'h0) & (phase_reg != PH_IDLE);
   assign fifo_pop = load_now & (phase_reg == PH_DATA) & fifo_valid;
   assign wr_finish = load_now & (phase_reg == PH_CHECK) & (byte_cnt_reg == chk_len);
   // Serial output takes buffer data, then the check bytes
   assign tx_byte = (phase_reg == PH_DATA) ? (fifo_valid ? fifo_data : 8'h00) :
                    is_data_reg ? ~rs_top :
                    ((byte_cnt_reg == 11'h000) ? crc_reg[15:8] : crc_reg[7:0]);

   assign rx_done = bit_tick & ~write_reg & (bit_cnt_reg == 3'h7) & (phase_reg != PH_IDLE);
   assign rx_byte = {sh_reg[6:0], rdat_s2_reg};
   assign byte_event = write_reg ? (load_now & ~wr_finish) : rx_done;

   // Encoder steps on data bytes; in the check phase it only shifts out
   assign rs_step = byte_event & is_data_reg;
   assign rs_fb = (phase_reg == PH_DATA) ? ((write_reg ? tx_byte : rx_byte) ^ rs_top) : 8'h00;
   assign crc_step = byte_event & ~is_data_reg & (~write_reg | (phase_reg == PH_DATA));
   assign crc_nx = crc_byte(crc_reg, write_reg ? tx_byte : rx_byte);
   assign syn_now = rx_byte ^ ~rs_top;

   assign gpow_nx = gf_mul(gpow_reg, (gst_reg == G_BETA) ? `DFE_GF_BETA : galpha_reg);
   assign root_hit = (gcnt_reg == `DFE_ROOT_A) | (gcnt_reg == `DFE_ROOT_B) |
                     (gcnt_reg == `DFE_ROOT_C) | (gcnt_reg == `DFE_ROOT_D) |
                     (gcnt_reg == `DFE_ROOT_E);

   genvar gj;
   generate
      for (gj = 0; gj < 6; gj = gj + 1) begin : g_mul
         assign rs_prod[gj] = gf_mul(rs_fb, deg6_reg ? D6_COEFS[gj*8 +: 8] : c5_mem[gj]);
         assign c5_prod[gj] = gf_mul(gpow_reg, c5_mem[gj]);
      end
   endgenerate

   dfe_fifo #(
      .WIDTH(`DFE_FIFO_WIDTH),
      .DEPTH(`DFE_FIFO_DEPTH),
      .AW(`DFE_FIFO_AW)
   ) u_tx_fifo (
      .clk(sys_clk),
      .rst(rst),
      .in_valid(wr_valid),
      .in_data(wr_data),
      .in_ready(wr_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_data),
      .out_ready(fifo_pop)
   );

   // Degree 5 generator built at start-up from alpha = beta^88
   always @(posedge sys_clk or posedge rst) begin : gen_build
      integer j;
      if (rst) begin
         gst_reg <= G_BETA;
         gcnt_reg <= 8'h00;
         gpow_reg <= `DFE_GF_ONE;
         galpha_reg <= `DFE_GF_ONE;
         gen_ready <= 1'b0;
         c5_mem[0] <= `DFE_GF_ONE;
         for (j = 1; j < 6; j = j + 1) begin
            c5_mem[j] <= 8'h00;
         end
      end else begin
         case (gst_reg)
            G_BETA: begin
               gpow_reg <= gpow_nx;
               gcnt_reg <= gcnt_reg + 8'h01;
               if (gcnt_reg == `DFE_ALPHA_EXP - 8'h01) begin
                  galpha_reg <= gpow_nx;
                  gpow_reg <= `DFE_GF_ONE;
                  gcnt_reg <= 8'h00;
                  gst_reg <= G_ROOTS;
               end
            end
            G_ROOTS: begin
               if (root_hit) begin
                  c5_mem[0] <= c5_prod[0];
                  for (j = 1; j < 6; j = j + 1) begin
                     c5_mem[j] <= c5_mem[j-1] ^ c5_prod[j];
                  end
               end
               gpow_reg <= gpow_nx;
               gcnt_reg <= gcnt_reg + 8'h01;
               if (gcnt_reg == `DFE_ORDER_LAST) begin
                  gst_reg <= G_DONE;
                  gen_ready <= 1'b1;
               end
            end
            default: begin
               gen_ready <= 1'b1;
            end
         endcase
      end
   end

   // Link sampling
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rclk_s1_reg <= 1'b0;
         rclk_s2_reg <= 1'b0;
         rclk_s3_reg <= 1'b0;
         rdat_s1_reg <= 1'b0;
         rdat_s2_reg <= 1'b0;
      end else begin
         rclk_s1_reg <= read_reference_clock;
         rclk_s2_reg <= rclk_s1_reg;
         rclk_s3_reg <= rclk_s2_reg;
         rdat_s1_reg <= serial_read_in;
         rdat_s2_reg <= rdat_s1_reg;
      end
   end

   // Field sequencing, serialiser, deserialiser and checkers
   always @(posedge sys_clk or posedge rst) begin : field_seq
      integer j;
      if (rst) begin
         phase_reg <= PH_IDLE;
         is_data_reg <= 1'b0;
         write_reg <= 1'b0;
         deg6_reg <= 1'b0;
         il5_reg <= 1'b0;
         len_reg <= 11'h000;
         bit_cnt_reg <= 3'h0;
         byte_cnt_reg <= 11'h000;
         il_reg <= 3'h0;
         sh_reg <= 8'h00;
         crc_reg <= `DFE_CRC_INIT_ZERO;
         syn_any_reg <= 1'b0;
         serial_write_out <= 1'b0;
         field_busy <= 1'b0;
         field_done <= 1'b0;
         wr_underrun <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= 8'h00;
         crc_error <= 1'b0;
         ecc_error <= 1'b0;
         for (j = 0; j < 30; j = j + 1) begin
            rs_mem[j] <= 8'h00;
            syn_mem[j] <= 8'h00;
         end
      end else begin
         field_done <= 1'b0;
         rd_valid <= 1'b0;
         if (field_start & gen_ready & (phase_reg == PH_IDLE)) begin
            phase_reg <= PH_DATA;
            is_data_reg <= field_is_data;
            write_reg <= field_write;
            deg6_reg <= ecc_degree6;
            il5_reg <= interleave5;
            len_reg <= field_len;
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 11'h000;
            il_reg <= 3'h0;
            crc_reg <= crc_init_ones ? `DFE_CRC_INIT_ONE : `DFE_CRC_INIT_ZERO;
            syn_any_reg <= 1'b0;
            field_busy <= 1'b1;
            wr_underrun <= 1'b0;
            crc_error <= 1'b0;
            ecc_error <= 1'b0;
            for (j = 0; j < 30; j = j + 1) begin
               rs_mem[j] <= 8'h00;
            end
         end else if (bit_tick & (phase_reg != PH_IDLE)) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (write_reg) begin
               if (wr_finish) begin
                  phase_reg <= PH_IDLE;
                  field_busy <= 1'b0;
                  field_done <= 1'b1;
                  serial_write_out <= 1'b0;
                  bit_cnt_reg <= 3'h0;
               end else if (bit_cnt_reg == 3'h0) begin
                  serial_write_out <= tx_byte[7];
                  sh_reg <= {tx_byte[6:0], 1'b0};
                  if ((phase_reg == PH_DATA) & ~fifo_valid) begin
                     wr_underrun <= 1'b1;
                  end
               end else begin
                  serial_write_out <= sh_reg[7];
                  sh_reg <= {sh_reg[6:0], 1'b0};
               end
            end else begin
               sh_reg <= rx_byte;
               if (rx_done & (phase_reg == PH_DATA)) begin
                  rd_valid <= 1'b1;
                  rd_data <= rx_byte;
               end
            end
            if (crc_step) begin
               crc_reg <= crc_nx;
            end
            if (rs_step) begin
               rs_mem[base] <= rs_prod[0];
               for (j = 1; j < 6; j = j + 1) begin
                  rs_mem[base + j[4:0]] <= rs_mem[base + j[4:0] - 5'h01] ^ rs_prod[j];
               end
            end
            if (rx_done & (phase_reg == PH_CHECK) & is_data_reg) begin
               syn_mem[byte_cnt_reg[4:0]] <= syn_now;
               if (syn_now != 8'h00) begin
                  syn_any_reg <= 1'b1;
               end
            end
            if (byte_event) begin
               il_reg <= (il_reg == il_last) ? 3'h0 : il_reg + 3'h1;
               byte_cnt_reg <= byte_cnt_reg + 11'h001;
               if ((phase_reg == PH_DATA) & (byte_cnt_reg == len_reg - 11'h001)) begin
                  phase_reg <= PH_CHECK;
                  byte_cnt_reg <= 11'h000;
                  il_reg <= 3'h0;
               end
               if (~write_reg & (phase_reg == PH_CHECK) &
                   (byte_cnt_reg == chk_len - 11'h001)) begin
                  phase_reg <= PH_IDLE;
                  field_busy <= 1'b0;
                  field_done <= 1'b1;
                  bit_cnt_reg <= 3'h0;
                  if (is_data_reg) begin
                     ecc_error <= syn_any_reg | (syn_now != 8'h00);
                  end else begin
                     crc_error <= (crc_nx != 16'h0000);
                  end
               end
            end
         end
      end
   end

   // Composite syndrome readout
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         syndrome_byte <= 8'h00;
      end else if (syndrome_index < `DFE_CHK_MAX) begin
         syndrome_byte <= syn_mem[syndrome_index];
      end else begin
         syndrome_byte <= 8'h00;
      end
   end
endmodule
`default_nettype wire

/* tb/dfe_checker.sv */
// Concurrent checks on the field control and status ports
`timescale 1ns/10ps
`default_nettype none
module dfe_chk (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Field control
   input wire logic field_start,
   input wire logic field_busy,
   input wire logic field_done,
   input wire logic gen_ready,
   // Data and status
   input wire logic serial_write_out,
   input wire logic rd_valid,
   input wire logic wr_underrun,
   input wire logic crc_error,
   input wire logic ecc_error,
   input wire logic [4:0] syndrome_index,
   input wire logic [7:0] syndrome_byte
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic took;
   assign took = field_start && gen_ready && !field_busy;

   a_start_clears: assert property (took |=> field_busy && !crc_error && !ecc_error)
      else $error("accepted start did not clear flags");
   a_start_refused: assert property (field_start && !gen_ready |=> !field_busy)
      else $error("start taken before generator ready");
   a_done_ends: assert property (field_done |-> !field_busy ##1 !field_done)
      else $error("done pulse malformed");
   a_byte_minimum: assert property ($rose(field_busy) |-> !field_done [*8])
      else $error("field ended within a byte time");
   a_flags_hold: assert property (field_busy && $past(field_busy) |->
      $stable(ecc_error) && $stable(crc_error))
      else $error("error flag moved inside a field");
   a_ecc_at_end: assert property ($rose(ecc_error) |-> field_done)
      else $error("ecc flag rose outside field end");
   a_crc_at_end: assert property ($rose(crc_error) |-> field_done)
      else $error("crc flag rose outside field end");
   a_idle_quiet: assert property (!field_busy |-> !serial_write_out)
      else $error("write line active outside a field");
   a_read_in_field: assert property (rd_valid |-> $past(field_busy))
      else $error("read byte outside a field");
   a_syn_range: assert property (syndrome_index > 5'd29 |=> syndrome_byte == 8'h00)
      else $error("syndrome beyond range not zero");
   a_under_field: assert property ($rose(wr_underrun) |-> field_busy)
      else $error("underrun outside a field");

   c_ecc: cover property ($rose(ecc_error));
   c_crc: cover property ($rose(crc_error));
   c_under: cover property ($rose(wr_underrun));
endmodule

bind dfe_error_code_unit dfe_chk u_chk (.sys_clk, .rst, .field_start, .field_busy, .field_done,
   .gen_ready, .serial_write_out, .rd_valid, .wr_underrun, .crc_error, .ecc_error,
   .syndrome_index, .syndrome_byte);
`default_nettype wire

/* tb/dfe_link_model.sv */
// Disk channel model: reference clock, serial read source, write capture
`timescale 1ns/10ps
`default_nettype none
module dfe_link_model (
   // Link
   output logic read_reference_clock,
   output logic serial_read_in,
   input wire logic serial_write_out
);
   logic sending;
   logic cap[$];
   // Runs free since it also paces writes; every edge lands 12 ns after a sys_clk rise
   initial begin
      read_reference_clock = 1'b0;
      serial_read_in = 1'b0;
      sending = 1'b0;
      #37;
      forever #200 read_reference_clock = ~read_reference_clock;
   end
   always @(posedge read_reference_clock) cap.push_back(serial_write_out);
   // Released line wanders so stale bits cannot pass
   always @(negedge read_reference_clock) begin
      if (!sending) serial_read_in <= ~serial_read_in;
   end
   // MSB first, changed on the fall, steady across the rise
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sending = 1'b1;
         serial_read_in = b[i];
         @(negedge read_reference_clock);
      end
   endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the disk field CRC and Reed-Solomon unit
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic sys_clk, rst, read_reference_clock, serial_read_in, serial_write_out;
   logic field_start, field_is_data, field_write, crc_init_ones, ecc_degree6, interleave5;
   logic [10:0] field_len;
   logic field_busy, field_done, gen_ready, wr_valid, wr_ready, wr_underrun, rd_valid;
   logic [7:0] wr_data, rd_data, syndrome_byte;
   logic crc_error, ecc_error;
   logic [4:0] syndrome_index;
   logic [7:0] fr[$];
   logic [7:0] rq[$];
   logic [7:0] g[6];
   int n_fail = 0;
   int check_count = 0;

   dfe_error_code_unit u_dut (.sys_clk, .rst, .read_reference_clock, .serial_read_in,
      .serial_write_out, .field_start, .field_is_data, .field_write, .crc_init_ones,
      .ecc_degree6, .interleave5, .field_len, .field_busy, .field_done, .gen_ready,
      .wr_valid, .wr_data, .wr_ready, .wr_underrun, .rd_valid, .rd_data, .crc_error,
      .ecc_error, .syndrome_index, .syndrome_byte);
   dfe_link_model u_link (.read_reference_clock, .serial_read_in, .serial_write_out);

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) if (rd_valid === 1'b1) rq.push_back(rd_data);

   task automatic ck(input logic bad, input string m);
      check_count++;
      if (bad !== 1'b0) begin
         n_fail++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask

   function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      p = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         p = {p[6:0], 1'b0} ^ (p[7] ? 8'h2d : 8'h00);
         if (b[i]) p = p ^ a;
      end
      return p;
   endfunction

   function automatic logic [7:0] gpow(input logic [7:0] a, input int n);
      logic [7:0] p;
      p = 8'h01;
      repeat (n) p = gmul(p, a);
      return p;
   endfunction

   task automatic mkgen(input logic d6);
      logic [7:0] al, r;
      logic [7:0] p[7];
      al = gpow(8'h02, 88);
      p = '{default: 8'h00};
      p[0] = 8'h01;
      for (int k = 0; k < (d6 ? 6 : 5); k++) begin
         r = gpow(al, d6 ? 125 + k : (k + 253) % 255);
         for (int j = 6; j > 0; j--) p[j] = p[j - 1] ^ gmul(r, p[j]);
         p[0] = gmul(r, p[0]);
      end
      for (int j = 0; j < 6; j++) g[j] = p[j];
   endtask

   task automatic mkframe(input logic dat, d6, i5, one, input int len, got);
      logic [15:0] c;
      logic [7:0] r[5][6];
      logic [7:0] b, fb;
      int n, d;
      fr.delete();
      c = one ? 16'hffff : 16'h0000;
      r = '{default: 8'h00};
      n = i5 ? 5 : 3;
      d = d6 ? 6 : 5;
      mkgen(d6);
      for (int k = 0; k < len; k++) begin
         b = (k < got) ? 8'(k * 37 + 5) : 8'h00;
         fr.push_back(b);
         for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0);
         fb = b ^ r[k % n][d - 1];
         for (int j = d - 1; j > 0; j--) r[k % n][j] = r[k % n][j - 1] ^ gmul(fb, g[j]);
         r[k % n][0] = gmul(fb, g[0]);
      end
      if (!dat) begin
         fr.push_back(c[15:8]);
         fr.push_back(c[7:0]);
      end else for (int t = 0; t < n * d; t++) fr.push_back(~r[t % n][d - 1 - t / n]);
   endtask

   task automatic push(input int cnt);
      for (int k = 0; k < cnt; k++) begin
         wr_valid <= 1'b1;
         wr_data <= 8'(k * 37 + 5);
         @(posedge sys_clk);
      end
      wr_valid <= 1'b0;
   endtask

   task automatic start(input logic dat, wr, d6, i5, one, input int len);
      field_is_data <= dat;
      field_write <= wr;
      ecc_degree6 <= d6;
      interleave5 <= i5;
      crc_init_ones <= one;
      field_len <= 11'(len);
      field_start <= 1'b1;
      @(posedge sys_clk);
      field_start <= 1'b0;
   endtask

   task automatic wait_done;
      int w;
      w = 0;
      while (field_done !== 1'b1 && w < 5000) begin
         @(posedge sys_clk);
         #1;
         w++;
      end
      ck(w >= 5000, "field never finished");
   endtask

   task automatic t_write(input logic dat, d6, i5, one, input int len, got, input logic fill);
      logic ok, m;
      mkframe(dat, d6, i5, one, len, got);
      push(fill ? 16 : got);
      if (fill) begin
         repeat (2) @(posedge sys_clk);
         ck(wr_ready !== 1'b0, "full buffer still ready");
      end
      u_link.cap.delete();
      start(dat, 1'b1, d6, i5, one, len);
      wait_done;
      repeat (20) @(posedge sys_clk);
      ok = 1'b0;
      for (int o = 0; o < 4; o++) begin
         m = 1'b1;
         for (int i = 0; i < fr.size() * 8; i++)
            if (o + i >= u_link.cap.size() || u_link.cap[o + i] !== fr[i / 8][7 - i % 8]) m = 1'b0;
         ok = ok | m;
      end
      ck(ok !== 1'b1, "serial write stream");
      ck(wr_underrun !== (got < len), "underrun flag");
      ck(wr_ready !== 1'b1, "buffer not drained");
   endtask

   task automatic t_read(input logic dat, d6, i5, one, input int len, flip);
      logic [7:0] s, rt;
      int n, d;
      s = 8'h00;
      n = i5 ? 5 : 3;
      d = d6 ? 6 : 5;
      rt = gpow(gpow(8'h02, 88), d6 ? 125 : 253);
      mkframe(dat, d6, i5, one, len, len);
      if (flip >= 0) fr[len + flip] = fr[len + flip] ^ 8'h10;
      rq.delete();
      @(negedge read_reference_clock);
      @(posedge sys_clk);
      start(dat, 1'b0, d6, i5, one, len);
      fork
         foreach (fr[i]) u_link.send_byte(fr[i]);
         wait_done;
      join
      u_link.sending = 1'b0;
      ck((dat ? ecc_error : crc_error) !== (flip >= 0), "error flag");
      if (dat) begin
         ck(rq.size() != len, "read byte count");
         foreach (rq[i]) ck(rq[i] !== fr[i], "read byte value");
         for (int t = 0; t < 31; t++) begin
            syndrome_index <= 5'(t);
            repeat (2) @(posedge sys_clk);
            #1;
            ck(syndrome_byte !== ((t == flip) ? 8'h10 : 8'h00), "syndrome byte");
            // Host side: reduce the flipped interleave's syndrome by its first root factor
            if (t < n * d && flip >= 0 && t % n == flip % n) s = gmul(s, rt) ^ syndrome_byte;
         end
         ck(s !== ((flip >= 0) ? gmul(8'h10, gpow(rt, d - 1 - flip / n)) : 8'h00),
            "individual syndrome");
      end
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge sys_clk);
      n_fail++;
      $display("unexpected at %0t: watchdog expired", $time);
      results;
   end

   initial begin
      rst = 1'b1;
      {field_start, field_is_data, field_write, crc_init_ones, ecc_degree6, interleave5} = '0;
      field_len = '0;
      wr_valid = 1'b0;
      wr_data = '0;
      syndrome_index = '0;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      start(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4);
      repeat (3) @(posedge sys_clk);
      ck(field_busy !== 1'b0, "start taken before ready");
      repeat (400) if (gen_ready !== 1'b1) @(posedge sys_clk);
      ck(gen_ready !== 1'b1, "generator never ready");
      // Field lengths below stay far inside the per-mode data limits
      t_write(1'b0, 1'b0, 1'b0, 1'b0, 4, 4, 1'b0);
      t_write(1'b0, 1'b0, 1'b0, 1'b1, 4, 4, 1'b0);
      t_write(1'b1, 1'b0, 1'b0, 1'b0, 7, 7, 1'b0);
      t_write(1'b1, 1'b0, 1'b1, 1'b0, 7, 7, 1'b0);
      t_write(1'b1, 1'b1, 1'b0, 1'b0, 16, 16, 1'b1);
      t_write(1'b1, 1'b1, 1'b1, 1'b0, 7, 7, 1'b0);
      t_write(1'b1, 1'b0, 1'b0, 1'b0, 5, 2, 1'b0);
      t_read(1'b0, 1'b0, 1'b0, 1'b1, 4, -1);
      t_read(1'b0, 1'b0, 1'b0, 1'b0, 4, 0);
      t_read(1'b1, 1'b1, 1'b1, 1'b0, 9, -1);
      t_read(1'b1, 1'b0, 1'b0, 1'b0, 6, 4);
      t_read(1'b1, 1'b1, 1'b0, 1'b0, 6, 17);
      results;
   end
endmodule
`default_nettype wire
